/* File: hw/ulfc_top.sv */
// uart line control: halt/resume, rs485 direction, multidrop, half duplex
`timescale 1ns/1ns
`default_nettype none
module ulfc_top
    import ulfc_pkg::*;
(
    input  wire logic              clock_i,
    input  wire logic              rst_i,
    input  wire logic [2:0]        flow_mode_i,
    input  wire logic              half_duplex_i,
    input  wire logic [2:0]        pin_mode_i,
    input  wire logic              dir_polarity_i,
    input  wire logic [3:0]        turnaround_delay_i,
    input  wire logic [7:0]        resume_char_i,
    input  wire logic [7:0]        halt_char_i,
    input  wire logic              bit_tick_i,
    input  wire logic              rx_valid_i,
    input  wire logic [CHAR_W-1:0] rx_char_i,
    output logic                   rx_out_valid_o,
    output logic [BYTE_W-1:0]      rx_out_data_o,
    input  wire logic              rx_out_ready_i,
    output logic                   rx_overrun_o,
    output logic                   rx_enable_o,
    input  wire logic              tx_in_valid_i,
    input  wire logic [CHAR_W-1:0] tx_in_data_i,
    output logic                   tx_in_ready_o,
    output logic                   tx_out_valid_o,
    output logic [CHAR_W-1:0]      tx_out_data_o,
    input  wire logic              tx_out_ready_i,
    input  wire logic              tx_shift_busy_i,
    output logic                   driver_direction_out_o
);
    ulfc_state_t s_ff;
    ulfc_state_t nxt_s;
    logic        soft_mode;
    logic        md_mode;
    logic        rs485;
    logic        tx_active;
    logic        rx_ok;
    logic        is_uni;
    logic        is_multi;
    logic        accept;
    logic        release_c;
    logic        tx_done;
    logic        permit;

    ulfc_stream_if #(.W(BYTE_W)) rx_in_s ();
    ulfc_stream_if #(.W(BYTE_W)) rx_out_s ();

    // mode decode and shared conditions
    assign soft_mode = (flow_mode_i == FLOW_MODE_SOFT);
    assign md_mode = (flow_mode_i == FLOW_MODE_MD_TXON) ||
                     (flow_mode_i == FLOW_MODE_MD_TXMATCH);
    assign rs485 = (pin_mode_i == PIN_MODE_RS485);
    assign tx_active = s_ff.out_vld | s_ff.launched | tx_shift_busy_i;
    assign rx_ok = rx_valid_i & ~(half_duplex_i & tx_active);
    assign is_uni = (rx_char_i[7:0] == resume_char_i);
    assign is_multi = (rx_char_i[7:0] == halt_char_i);
    assign accept = tx_in_valid_i & s_ff.in_rdy;
    assign release_c = s_ff.out_vld & tx_out_ready_i;
    assign tx_done = ~s_ff.hold_vld & ~s_ff.launched & ~tx_shift_busy_i & ~s_ff.out_vld;

    // next state of the whole block
    always_comb begin
        nxt_s = s_ff;
        nxt_s.rx_push = 1'b0;
        nxt_s.rx_data = rx_char_i[7:0];
        // receive side: flow characters and addressing
        if (!soft_mode) begin
            nxt_s.paused = 1'b0;
        end
        if (!md_mode) begin
            nxt_s.match = 1'b0;
        end
        if (rx_ok) begin
            if (soft_mode) begin
                if (is_multi) begin
                    nxt_s.paused = 1'b1;
                end else if (is_uni) begin
                    nxt_s.paused = 1'b0;
                end else begin
                    nxt_s.rx_push = 1'b1;
                end
            end else if (md_mode) begin
                if (rx_char_i[8]) begin
                    nxt_s.match = is_uni | is_multi;
                end else begin
                    nxt_s.rx_push = s_ff.match;
                end
            end else begin
                nxt_s.rx_push = 1'b1;
            end
        end
        nxt_s.rx_en = ~md_mode | nxt_s.match;
        nxt_s.overrun = s_ff.rx_push & ~rx_in_s.ready;
        // transmit holding stage; in-flight char is never cut
        nxt_s.launched = release_c | (s_ff.launched & ~tx_shift_busy_i);
        if (release_c) begin
            nxt_s.hold_vld = 1'b0;
        end
        if (accept) begin
            nxt_s.hold_vld = 1'b1;
            nxt_s.hold_data = tx_in_data_i;
        end
        nxt_s.in_rdy = ~nxt_s.hold_vld;
        // direction sequencer
        case (s_ff.dir_state)
            DIR_IDLE: begin
                if (rs485 && s_ff.hold_vld) begin
                    nxt_s.dir_state = DIR_SEND;
                end
            end
            DIR_SEND: begin
                if (!rs485) begin
                    nxt_s.dir_state = DIR_IDLE;
                end else if (tx_done) begin
                    if (turnaround_delay_i == DELAY_NONE) begin
                        nxt_s.dir_state = DIR_IDLE;
                    end else begin
                        nxt_s.dir_state = DIR_HOLD;
                        nxt_s.delay_cnt = turnaround_delay_i;
                    end
                end
            end
            DIR_HOLD: begin
                if (!rs485) begin
                    nxt_s.dir_state = DIR_IDLE;
                end else if (s_ff.hold_vld) begin
                    nxt_s.dir_state = DIR_SEND;
                end else if (bit_tick_i) begin
                    if (s_ff.delay_cnt == DELAY_LAST) begin
                        nxt_s.dir_state = DIR_IDLE;
                    end else begin
                        nxt_s.delay_cnt = s_ff.delay_cnt - DELAY_LAST;
                    end
                end
            end
            default: begin
                nxt_s.dir_state = DIR_IDLE;
            end
        endcase
        // tx offered only when unpaused, addressed in mode 4 and, in rs485 mode, the driver is already on
        permit = ~nxt_s.paused &
                 ((flow_mode_i != FLOW_MODE_MD_TXMATCH) | nxt_s.match) &
                 (~rs485 | (s_ff.dir_state == DIR_SEND));
        nxt_s.out_vld = nxt_s.hold_vld & permit;
        nxt_s.dir_pin = (rs485 && nxt_s.dir_state != DIR_IDLE) ?
                        dir_polarity_i : ~dir_polarity_i;
    end

    // state register
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            s_ff <= '{dir_state: DIR_IDLE, in_rdy: 1'b1, dir_pin: 1'b1, rx_en: 1'b1,
                      default: '0};
        end else begin
            s_ff <= nxt_s;
        end
    end

    // receive path buffer toward the rx fifo
    assign rx_in_s.valid = s_ff.rx_push;
    assign rx_in_s.data = s_ff.rx_data;
    ulfc_buf2 #(.W(BYTE_W)) u_rx_buf (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .in_s    (rx_in_s),
        .out_s   (rx_out_s)
    );
    assign rx_out_valid_o = rx_out_s.valid;
    assign rx_out_data_o = rx_out_s.data;
    assign rx_out_s.ready = rx_out_ready_i;

    // outputs from the state register
    assign rx_overrun_o = s_ff.overrun;
    assign rx_enable_o = s_ff.rx_en;
    assign tx_in_ready_o = s_ff.in_rdy;
    assign tx_out_valid_o = s_ff.out_vld;
    assign tx_out_data_o = s_ff.hold_data;
    assign driver_direction_out_o = s_ff.dir_pin;

    // checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    pause_mode_a: assert property (s_ff.paused |-> $past(flow_mode_i) == FLOW_MODE_SOFT)
        else $error("pause held outside soft flow mode");
    halt_stop_a: assert property (soft_mode && rx_ok && is_multi |=> !tx_out_valid_o)
        else $error("transmit offered after halt character");
    resume_go_a: assert property (soft_mode && rx_ok && is_uni && !is_multi |=> !s_ff.paused)
        else $error("resume character did not clear pause");
    dir_lead_a: assert property ($rose(tx_out_valid_o) && $past(rs485) |->
                                 $past(driver_direction_out_o) == $past(dir_polarity_i))
        else $error("data offered before direction asserted");
    dir_drop_a: assert property (rs485 && s_ff.dir_state == DIR_SEND && tx_done &&
                                 turnaround_delay_i == DELAY_NONE |=>
                                 driver_direction_out_o != $past(dir_polarity_i))
        else $error("direction not released after last stop");
    dir_pol_a: assert property (!rs485 |=> driver_direction_out_o != $past(dir_polarity_i))
        else $error("direction active outside rs485 mode");
    delay_hold_a: assert property (rs485 && s_ff.dir_state == DIR_SEND && tx_done &&
                                   turnaround_delay_i != DELAY_NONE && !bit_tick_i |=>
                                   driver_direction_out_o == $past(dir_polarity_i) ##1
                                   driver_direction_out_o == $past(dir_polarity_i, 2))
        else $error("direction dropped before turnaround delay");
    addr_drop_a: assert property (md_mode && rx_ok && rx_char_i[8] |=> !s_ff.rx_push)
        else $error("address byte stored in receive path");
    rx_off_a: assert property (md_mode && rx_ok && rx_char_i[8] && !is_uni && !is_multi
                               |=> !rx_enable_o)
        else $error("receiver still enabled after foreign address");
    tx_match_a: assert property (tx_out_valid_o && $past(flow_mode_i) == FLOW_MODE_MD_TXMATCH
                                 |-> rx_enable_o)
        else $error("mode 4 transmit without address match");
    half_dup_a: assert property (half_duplex_i && tx_active && rx_valid_i |=> !s_ff.rx_push)
        else $error("receive accepted while transmitting");

    pause_seen_c: cover property (soft_mode && rx_ok && is_multi ##[1:20] !s_ff.paused);
    hold_seen_c: cover property (s_ff.dir_state == DIR_HOLD ##[1:200] s_ff.dir_state == DIR_IDLE);
    match_data_c: cover property (md_mode && s_ff.match && s_ff.rx_push);
endmodule
`default_nettype wire

/* File: hw/ulfc_pkg.sv */
// constants, state types and encodings for the uart line flow control block
package ulfc_pkg;
    localparam int CHAR_W = 9;                   // received/sent character incl. ninth bit
    localparam int BYTE_W = 8;                   // byte stored toward the receive fifo
    localparam logic [2:0] FLOW_MODE_SOFT = 3'h2;    // in-band halt/resume flow control
    localparam logic [2:0] FLOW_MODE_MD_TXON = 3'h3; // multidrop, transmitter always on
    localparam logic [2:0] FLOW_MODE_MD_TXMATCH = 3'h4; // multidrop, transmitter on match
    localparam logic [2:0] PIN_MODE_RS485 = 3'h3;    // pin function code for auto direction
    localparam logic [3:0] DELAY_NONE = 4'h0;        // turnaround delay setting: none
    localparam logic [3:0] DELAY_LAST = 4'h1;        // last bit time of a running delay
    localparam logic [1:0] BUF_EMPTY = 2'h0;
    localparam logic [1:0] BUF_ONE = 2'h1;
    localparam logic [1:0] BUF_FULL = 2'h2;

    // driver direction sequencer, one-hot
    typedef enum logic [2:0] {
        DIR_IDLE = 3'b001,
        DIR_SEND = 3'b010,
        DIR_HOLD = 3'b100
    } ulfc_dir_t;

    typedef struct packed {
        logic               paused;
        logic               match;
        logic               launched;
        ulfc_dir_t          dir_state;
        logic [3:0]         delay_cnt;
        logic               hold_vld;
        logic [CHAR_W-1:0]  hold_data;
        logic               out_vld;
        logic               in_rdy;
        logic               dir_pin;
        logic               rx_en;
        logic               rx_push;
        logic [BYTE_W-1:0]  rx_data;
        logic               overrun;
    } ulfc_state_t;
endpackage

/* File: hw/ulfc_stream_if.sv */
// valid/ready byte stream between the block's modules
`timescale 1ns/1ns
`default_nettype none
interface ulfc_stream_if #(parameter int W = 8);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* File: hw/ulfc_buf2.sv */
// two-entry buffer with registered valid and ready
`timescale 1ns/1ns
`default_nettype none
module ulfc_buf2
    import ulfc_pkg::*;
#(
    parameter int W = 8
) (
    input  wire logic   clock_i,
    input  wire logic   rst_i,
    ulfc_stream_if.snk  in_s,
    ulfc_stream_if.src  out_s
);
    typedef struct packed {
        logic [1:0]   cnt;
        logic [W-1:0] e0;
        logic [W-1:0] e1;
        logic         vld;
        logic         rdy;
    } ulfc_buf_st_t;

    ulfc_buf_st_t s_ff;
    ulfc_buf_st_t nxt_s;
    logic         push;
    logic         pop;

    // head in e0, shift on pop, write behind the survivors
    always_comb begin
        nxt_s = s_ff;
        pop = s_ff.vld & out_s.ready;
        push = in_s.valid & s_ff.rdy;
        if (pop) begin
            nxt_s.e0 = s_ff.e1;
        end
        if (push) begin
            if (s_ff.cnt == BUF_EMPTY || (s_ff.cnt == BUF_ONE && pop)) begin
                nxt_s.e0 = in_s.data;
            end else begin
                nxt_s.e1 = in_s.data;
            end
        end
        nxt_s.cnt = s_ff.cnt + {1'b0, push} - {1'b0, pop};
        nxt_s.vld = (nxt_s.cnt != BUF_EMPTY);
        nxt_s.rdy = (nxt_s.cnt != BUF_FULL);
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign out_s.valid = s_ff.vld;
    assign out_s.data = s_ff.e0;
    assign in_s.ready = s_ff.rdy;
endmodule
`default_nettype wire

/* File: dv/ulfc_far_model.sv */
// far-side transmit shifter model: takes characters and stays busy for one frame
`timescale 1ns/1ns
`default_nettype none
module ulfc_far_model
    import ulfc_pkg::*;
#(
    parameter int BITS = 11
) (
    input  wire logic              clock_i,
    input  wire logic              rst_i,
    input  wire logic              bit_tick_i,
    input  wire logic              stall_i,
    input  wire logic              tx_valid_i,
    input  wire logic [CHAR_W-1:0] tx_data_i,
    output logic                   tx_ready_o,
    output logic                   busy_o,
    output logic [7:0]             sent_cnt_o,
    output logic [CHAR_W-1:0]      last_char_o
);
    logic [3:0] bits_ff;

    // a slow shifter refuses while stalled or still sending
    assign tx_ready_o = !busy_o && !stall_i;

    // frame timer: start, nine data bits and stop, one per bit tick
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            busy_o      <= 1'b0;
            bits_ff     <= 4'h0;
            sent_cnt_o  <= 8'h00;
            last_char_o <= '0;
        end else if (tx_valid_i && tx_ready_o) begin
            busy_o      <= 1'b1;
            bits_ff     <= 4'(BITS);
            sent_cnt_o  <= sent_cnt_o + 8'h01;
            last_char_o <= tx_data_i;
        end else if (busy_o && bit_tick_i) begin
            bits_ff <= bits_ff - 4'h1;
            busy_o  <= (bits_ff != 4'h1);
        end
    end
endmodule
`default_nettype wire

/* File: dv/ulfc_top_tb.sv */
// self-checking bench for the uart line flow control block
`timescale 1ns/1ns
`default_nettype none
module ulfc_top_tb
    import ulfc_pkg::*;
;
    logic              clock_i = 1'b0;
    logic              rst_i = 1'b1;
    logic [2:0]        flow_mode_i = 3'h0;
    logic              half_duplex_i = 1'b0;
    logic [2:0]        pin_mode_i = PIN_MODE_RS485;
    logic              dir_polarity_i = 1'b1;
    logic [3:0]        turnaround_delay_i = 4'h0;
    logic [7:0]        resume_char_i = 8'h11;
    logic [7:0]        halt_char_i = 8'h13;
    logic              bit_tick_i = 1'b0;
    logic [1:0]        tick_cnt = 2'h0;
    logic              rx_valid_i = 1'b0;
    logic [CHAR_W-1:0] rx_char_i = '0;
    logic              rx_out_ready_i = 1'b0;
    logic              tx_in_valid_i = 1'b0;
    logic [CHAR_W-1:0] tx_in_data_i = '0;
    logic              far_stall = 1'b0;
    logic              ovr_seen = 1'b0;
    logic              rx_out_valid_o, rx_overrun_o, rx_enable_o, tx_in_ready_o;
    logic              tx_out_valid_o, tx_out_ready_i, tx_shift_busy_i, driver_direction_out_o;
    logic [BYTE_W-1:0] rx_out_data_o;
    logic [CHAR_W-1:0] tx_out_data_o, last_char;
    logic [7:0]        sent_cnt;
    int                mismatches = 0;
    int                comparisons = 0;

    ulfc_top uut (.clock_i, .rst_i, .flow_mode_i, .half_duplex_i, .pin_mode_i, .dir_polarity_i,
        .turnaround_delay_i, .resume_char_i, .halt_char_i, .bit_tick_i, .rx_valid_i, .rx_char_i,
        .rx_out_valid_o, .rx_out_data_o, .rx_out_ready_i, .rx_overrun_o, .rx_enable_o,
        .tx_in_valid_i, .tx_in_data_i, .tx_in_ready_o, .tx_out_valid_o, .tx_out_data_o,
        .tx_out_ready_i, .tx_shift_busy_i, .driver_direction_out_o);

    ulfc_far_model far (.clock_i, .rst_i, .bit_tick_i, .stall_i(far_stall),
        .tx_valid_i(tx_out_valid_o), .tx_data_i(tx_out_data_o), .tx_ready_o(tx_out_ready_i),
        .busy_o(tx_shift_busy_i), .sent_cnt_o(sent_cnt), .last_char_o(last_char));

    // clock, one bit time every four clocks, sticky overrun flag
    always #25 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        bit_tick_i <= (tick_cnt == 2'h3);
        tick_cnt   <= tick_cnt + 2'h1;
        if (rx_overrun_o === 1'b1) begin
            ovr_seen <= 1'b1;
        end
    end

    task automatic tally_and_finish;
        if (mismatches == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // a wait that used up its bound ends the run
    task automatic bound(input int n);
        if (n >= 400) begin
            mismatches++;
            tally_and_finish();
        end
    endtask

    task automatic send_rx(input logic [CHAR_W-1:0] c);
        @(posedge clock_i);
        rx_valid_i <= 1'b1;
        rx_char_i  <= c;
        @(posedge clock_i);
        rx_valid_i <= 1'b0;
    endtask

    task automatic send_tx(input logic [CHAR_W-1:0] c);
        int n;
        n = 0;
        @(posedge clock_i);
        tx_in_valid_i <= 1'b1;
        tx_in_data_i  <= c;
        do begin
            @(posedge clock_i);
            n++;
        end while (tx_in_ready_o !== 1'b1 && n < 400);
        tx_in_valid_i <= 1'b0;
        bound(n);
    endtask

    task automatic pop(input logic [BYTE_W-1:0] exp);
        int n;
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while (rx_out_valid_o !== 1'b1 && n < 400);
        bound(n);
        check(rx_out_data_o, exp);
        rx_out_ready_i <= 1'b1;
        @(posedge clock_i);
        rx_out_ready_i <= 1'b0;
    endtask

    task automatic wait_sent(input logic [7:0] k);
        int n;
        n = 0;
        while ((sent_cnt !== k || tx_shift_busy_i !== 1'b0) && n < 400) begin
            @(posedge clock_i);
            n++;
        end
        bound(n);
    endtask

    // one character with auto direction; counts bit ticks from last stop to release
    task automatic run_tx(input logic [CHAR_W-1:0] c, input logic pol, input logic [3:0] dly);
        int n;
        int t;
        n = 0;
        t = 0;
        dir_polarity_i     <= pol;
        turnaround_delay_i <= dly;
        repeat (2) @(posedge clock_i);
        check(driver_direction_out_o, !pol);
        send_tx(c);
        while (tx_shift_busy_i !== 1'b1 && n < 400) begin
            if (tx_out_valid_o === 1'b1) check(driver_direction_out_o, pol);
            @(posedge clock_i);
            n++;
        end
        while (tx_shift_busy_i === 1'b1 && n < 400) begin
            @(posedge clock_i);
            n++;
        end
        while (driver_direction_out_o !== !pol && n < 400) begin
            t += int'(bit_tick_i);
            @(posedge clock_i);
            n++;
        end
        bound(n);
        check(t, dly);
        check(last_char, c);
    endtask

    // main sequence
    initial begin
        repeat (5) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        check({tx_in_ready_o, rx_enable_o, rx_out_valid_o, tx_out_valid_o}, 4'hC);
        run_tx(9'h0A5, 1'b1, DELAY_NONE);
        run_tx(9'h15A, 1'b0, 4'h3);
        run_tx(9'h033, 1'b1, 4'hF);
        flow_mode_i <= FLOW_MODE_SOFT;
        send_tx(9'h041);
        wait_sent(8'h04);
        send_tx(9'h042);
        send_rx({1'b0, halt_char_i});
        repeat (80) @(posedge clock_i);
        check({tx_shift_busy_i, sent_cnt, last_char}, {1'b0, 8'h04, 9'h041});
        check(rx_out_valid_o, 1'b0);
        send_rx({1'b0, resume_char_i});
        wait_sent(8'h05);
        check(last_char, 9'h042);
        // foreign address, lookalike data byte, then a matching address in modes 3 and 4
        for (int m = 3; m <= 4; m++) begin
            flow_mode_i <= 3'(m);
            send_rx({1'b1, 8'h77});
            send_rx({1'b0, resume_char_i});
            send_tx(9'h060);
            repeat (80) @(posedge clock_i);
            check({rx_enable_o, rx_out_valid_o}, 2'b00);
            check(sent_cnt, 8'h06);
            send_rx(m == 3 ? {1'b1, resume_char_i} : {1'b1, halt_char_i});
            send_rx({1'b0, 8'hC0 | 8'(m)});
            pop(8'hC0 | 8'(m));
            if (m == 4) wait_sent(8'h07);
        end
        // receive is ignored while a character is offered or shifting
        flow_mode_i   <= 3'h0;
        half_duplex_i <= 1'b1;
        far_stall     <= 1'b1;
        send_tx(9'h0F0);
        repeat (4) @(posedge clock_i); // direction first, then the offer, held by the stall
        check(tx_out_valid_o, 1'b1);
        send_rx(9'h0E1);
        far_stall <= 1'b0;
        wait_sent(8'h08);
        send_rx(9'h0E3);
        pop(8'hE3);
        // plain mode stores halt and resume; a third byte overflows the buffer
        half_duplex_i <= 1'b0;
        send_rx({1'b0, halt_char_i});
        send_rx({1'b0, resume_char_i});
        send_rx(9'h155);
        repeat (3) @(posedge clock_i);
        check(ovr_seen, 1'b1);
        pop(halt_char_i);
        pop(resume_char_i);
        // outside rs485 mode the direction stays inactive while sending
        pin_mode_i <= 3'h0;
        send_tx(9'h1AA);
        repeat (2) @(posedge clock_i);
        check(driver_direction_out_o, 1'b0);
        wait_sent(8'h09);
        check(driver_direction_out_o, 1'b0);
        check(rx_out_valid_o, 1'b0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
